// file: include/cmp_cfg.svh
// Register addresses, data widths, field positions and reset values of the comparator control block.
`ifndef CMP_CFG_SVH
`define CMP_CFG_SVH

`define CMP_ADDR_W          8
`define CMP_DATA_W          8

`define CMP0_CTRL_ADDR      8'h9a
`define CMP0_MODE_ADDR      8'h9b
`define CMP1_CTRL_ADDR      8'h9d
`define CMP1_MODE_ADDR      8'h9e
`define CMP0_INSEL_ADDR     8'h9f
`define CMP1_INSEL_ADDR     8'ha0

`define CMP_CTRL_ON_BIT     7
`define CMP_CTRL_RESULT_BIT 6
`define CMP_CTRL_RISE_BIT   5
`define CMP_CTRL_FALL_BIT   4
`define CMP_CTRL_PHYST_HI   3
`define CMP_CTRL_PHYST_LO   2
`define CMP_CTRL_NHYST_HI   1
`define CMP_CTRL_NHYST_LO   0

`define CMP_MODE_RIE_BIT    5
`define CMP_MODE_FIE_BIT    4
`define CMP_MODE_SPEED_HI   1
`define CMP_MODE_SPEED_LO   0

`define CMP_INSEL_PLUS_HI   5
`define CMP_INSEL_PLUS_LO   4
`define CMP_INSEL_MINUS_HI  1
`define CMP_INSEL_MINUS_LO  0

`define CMP_CTRL_RESET      8'h00
`define CMP_SPEED_RESET     2'h2
`define CMP_SEL_RESET       2'h0
`define CMP_BYTE_ZERO       8'h00

`endif

// file: include/cmp_pkg.sv
// Types shared by the comparator control block.
package cmp_pkg;

    typedef logic [1:0] cmp_sel2_t;

    typedef enum logic [1:0] {
        CMP_HYST_OFF,
        CMP_HYST_5MV,
        CMP_HYST_10MV,
        CMP_HYST_20MV
    } cmp_hyst_t;

endpackage

// file: include/cmp_edge_if.sv
// Carrier for the synchronised comparator level and its edge pulses.
`timescale 1ns/10ps
`default_nettype none

interface cmp_edge_if;
    logic level;
    logic rise;
    logic fall;

    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

`default_nettype wire

// file: rtl/cmp_sync.sv
// Two-stage synchroniser and edge detector for one raw comparator result.
`timescale 1ns/10ps
`default_nettype none

module cmp_sync
(
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic raw_in,
    input  wire logic enabled,
    cmp_edge_if.src   edge_o
);

    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= raw_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Edges count only while the comparator is powered.
    assign edge_o.level = sync_ff & enabled;
    assign edge_o.rise  = enabled & sync_ff & ~prev_ff;
    assign edge_o.fall  = enabled & ~sync_ff & prev_ff;

endmodule

`default_nettype wire

// file: rtl/cmp_flag.sv
// Sticky event flag that hardware sets and software writes.
`timescale 1ns/10ps
`default_nettype none

module cmp_flag
(
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic set_evt,
    input  wire logic wr_en,
    input  wire logic wr_val,
    output var  logic flag_q
);

    logic flag_ff;
    logic nxt_flag;

    // An event in the cycle of a clearing write still sets the flag.
    assign nxt_flag = set_evt ? 1'b1 : (wr_en ? wr_val : flag_ff);

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            flag_ff <= 1'b0;
        else
            flag_ff <= nxt_flag;
    end

    assign flag_q = flag_ff;

endmodule

`default_nettype wire

// file: rtl/cmp_top.sv
// Control and status logic for two on-chip voltage comparators.
//
// Contract
// - Two identical comparator channels; only channel 0 can request reset.
// - Channel 0 can raise a device reset request besides flags and interrupts.
// - Control bit 7 written 1 powers the comparator on, written 0 off.
// - Disabled comparator drives low on its port outputs and loses supply.
// - Read-only bit 6 shows the live result, high when plus exceeds minus.
// - Falling edge of the result sets flag bit 4.
// - Rising edge of the result sets flag bit 5.
// - Edge flags stay set until software writes zero; hardware never clears.
// - Rising and falling edges both can cause an interrupt request.
// - Bits 3:2 pick positive hysteresis off, 5, 10 or 20 mV.
// - Bits 1:0 pick negative hysteresis off, 5, 10 or 20 mV.
// - Each channel has a clock-synchronised output and a clockless raw output.
// - Input select register holds separate 2-bit plus and minus selections.
// - Mode bits 1:0 choose response speed, reset value 10, 00 fastest.
// - Mode bit 5 enables rising, bit 4 falling interrupts, both reset off.
`timescale 1ns/10ps
`default_nettype none
`include "cmp_cfg.svh"

module cmp_top
#(
    parameter int N_CMP = 2
)
(
    input  wire logic                 clk_sys,
    input  wire logic                 arst_n,
    input  wire logic [7:0]           sfr_addr,
    input  wire logic [7:0]           sfr_wdata,
    input  wire logic                 sfr_wr,
    input  wire logic                 sfr_rd,
    output var  logic [7:0]           sfr_rdata,
    input  wire logic [N_CMP-1:0]     cmp_raw_in,
    input  wire logic                 cmp0_reset_sel,
    output var  logic [N_CMP-1:0]     cmp_on,
    output var  cmp_pkg::cmp_hyst_t   pos_hyst_sel [N_CMP],
    output var  cmp_pkg::cmp_hyst_t   neg_hyst_sel [N_CMP],
    output var  cmp_pkg::cmp_sel2_t   response_speed_sel [N_CMP],
    output var  cmp_pkg::cmp_sel2_t   plus_input_sel [N_CMP],
    output var  cmp_pkg::cmp_sel2_t   minus_input_sel [N_CMP],
    output var  logic [N_CMP-1:0]     latched_cmp_out,
    output var  logic [N_CMP-1:0]     raw_cmp_out,
    output var  logic [N_CMP-1:0]     cmp_irq,
    output var  logic                 cmp0_reset_req
);

    import cmp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel state, plus the shared read data and reset request.

    logic      [N_CMP-1:0] on_ff;
    cmp_hyst_t             physt_ff [N_CMP];
    cmp_hyst_t             nhyst_ff [N_CMP];
    cmp_sel2_t             speed_ff [N_CMP];
    cmp_sel2_t             plus_ff  [N_CMP];
    cmp_sel2_t             minus_ff [N_CMP];
    logic      [N_CMP-1:0] rie_ff;
    logic      [N_CMP-1:0] fie_ff;
    logic      [N_CMP-1:0] latched_ff;
    logic      [N_CMP-1:0] irq_ff;
    logic      [N_CMP-1:0] rise_seen_flag;
    logic      [N_CMP-1:0] fall_seen_flag;
    logic      [N_CMP-1:0] level_w;
    logic      [N_CMP-1:0] hit_ctrl;
    logic      [N_CMP-1:0] hit_mode;
    logic      [N_CMP-1:0] hit_insel;
    logic      [N_CMP-1:0] wr_ctrl;
    logic      [N_CMP-1:0] wr_mode;
    logic      [N_CMP-1:0] wr_insel;
    logic      [7:0]       ctrl_rd  [N_CMP];
    logic      [7:0]       mode_rd  [N_CMP];
    logic      [7:0]       insel_rd [N_CMP];
    logic      [7:0]       rdata_ff;
    logic      [7:0]       nxt_rdata;
    logic                  reset_req_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Channel logic, identical for every comparator.

    generate
        for (genvar i = 0; i < N_CMP; i++)
        begin : g_cmp
            localparam logic [7:0] CTRL_ADDR  = (i == 0) ? `CMP0_CTRL_ADDR  : `CMP1_CTRL_ADDR;
            localparam logic [7:0] MODE_ADDR  = (i == 0) ? `CMP0_MODE_ADDR  : `CMP1_MODE_ADDR;
            localparam logic [7:0] INSEL_ADDR = (i == 0) ? `CMP0_INSEL_ADDR : `CMP1_INSEL_ADDR;

            cmp_edge_if edge_bus ();

            assign hit_ctrl[i]  = (sfr_addr == CTRL_ADDR);
            assign hit_mode[i]  = (sfr_addr == MODE_ADDR);
            assign hit_insel[i] = (sfr_addr == INSEL_ADDR);
            assign wr_ctrl[i]   = sfr_wr & hit_ctrl[i];
            assign wr_mode[i]   = sfr_wr & hit_mode[i];
            assign wr_insel[i]  = sfr_wr & hit_insel[i];

            cmp_sync u_sync
            (
                .clk_sys (clk_sys),
                .arst_n  (arst_n),
                .raw_in  (cmp_raw_in[i]),
                .enabled (on_ff[i]),
                .edge_o  (edge_bus.src)
            );

            assign level_w[i] = edge_bus.level;

            cmp_flag u_rise_flag
            (
                .clk_sys (clk_sys),
                .arst_n  (arst_n),
                .set_evt (edge_bus.rise),
                .wr_en   (wr_ctrl[i]),
                .wr_val  (sfr_wdata[`CMP_CTRL_RISE_BIT]),
                .flag_q  (rise_seen_flag[i])
            );

            cmp_flag u_fall_flag
            (
                .clk_sys (clk_sys),
                .arst_n  (arst_n),
                .set_evt (edge_bus.fall),
                .wr_en   (wr_ctrl[i]),
                .wr_val  (sfr_wdata[`CMP_CTRL_FALL_BIT]),
                .flag_q  (fall_seen_flag[i])
            );

            // Control register: power and hysteresis.
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    on_ff[i]    <= 1'b0;
                    physt_ff[i] <= CMP_HYST_OFF;
                    nhyst_ff[i] <= CMP_HYST_OFF;
                end
                else if (wr_ctrl[i])
                begin
                    on_ff[i]    <= sfr_wdata[`CMP_CTRL_ON_BIT];
                    physt_ff[i] <= cmp_hyst_t'(sfr_wdata[`CMP_CTRL_PHYST_HI:`CMP_CTRL_PHYST_LO]);
                    nhyst_ff[i] <= cmp_hyst_t'(sfr_wdata[`CMP_CTRL_NHYST_HI:`CMP_CTRL_NHYST_LO]);
                end
            end

            // Mode register: response speed and interrupt enables.
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    speed_ff[i] <= `CMP_SPEED_RESET;
                    rie_ff[i]   <= 1'b0;
                    fie_ff[i]   <= 1'b0;
                end
                else if (wr_mode[i])
                begin
                    speed_ff[i] <= sfr_wdata[`CMP_MODE_SPEED_HI:`CMP_MODE_SPEED_LO];
                    rie_ff[i]   <= sfr_wdata[`CMP_MODE_RIE_BIT];
                    fie_ff[i]   <= sfr_wdata[`CMP_MODE_FIE_BIT];
                end
            end

            // Input select register.
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    plus_ff[i]  <= `CMP_SEL_RESET;
                    minus_ff[i] <= `CMP_SEL_RESET;
                end
                else if (wr_insel[i])
                begin
                    plus_ff[i]  <= sfr_wdata[`CMP_INSEL_PLUS_HI:`CMP_INSEL_PLUS_LO];
                    minus_ff[i] <= sfr_wdata[`CMP_INSEL_MINUS_HI:`CMP_INSEL_MINUS_LO];
                end
            end

            // Clocked output and interrupt request.
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    latched_ff[i] <= 1'b0;
                    irq_ff[i]     <= 1'b0;
                end
                else
                begin
                    latched_ff[i] <= level_w[i];
                    irq_ff[i]     <= (rise_seen_flag[i] & rie_ff[i]) | (fall_seen_flag[i] & fie_ff[i]);
                end
            end

            assign ctrl_rd[i]  = {on_ff[i], level_w[i], rise_seen_flag[i], fall_seen_flag[i],
                                  2'(physt_ff[i]), 2'(nhyst_ff[i])};
            assign mode_rd[i]  = {2'h0, rie_ff[i], fie_ff[i], 2'h0, speed_ff[i]};
            assign insel_rd[i] = {2'h0, plus_ff[i], 2'h0, minus_ff[i]};

            assign pos_hyst_sel[i]       = physt_ff[i];
            assign neg_hyst_sel[i]       = nhyst_ff[i];
            assign response_speed_sel[i] = speed_ff[i];
            assign plus_input_sel[i]     = plus_ff[i];
            assign minus_input_sel[i]    = minus_ff[i];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Register read port; unmapped addresses read zero.

    always_comb
    begin
        nxt_rdata = `CMP_BYTE_ZERO;
        for (int k = 0; k < N_CMP; k++)
        begin
            if (hit_ctrl[k])
                nxt_rdata = ctrl_rd[k];
            else if (hit_mode[k])
                nxt_rdata = mode_rd[k];
            else if (hit_insel[k])
                nxt_rdata = insel_rd[k];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            rdata_ff <= `CMP_BYTE_ZERO;
        else if (sfr_rd)
            rdata_ff <= nxt_rdata;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset request from channel 0 only: it asks for reset while enabled,
    // selected as a reset source and reporting a low result.

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            reset_req_ff <= 1'b0;
        else
            reset_req_ff <= cmp0_reset_sel & on_ff[0] & ~level_w[0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign sfr_rdata       = rdata_ff;
    assign cmp_on          = on_ff;
    assign latched_cmp_out = latched_ff;
    assign cmp_irq         = irq_ff;
    assign cmp0_reset_req  = reset_req_ff;

    // The raw output must work without the clock, so it is only gated by the
    // power register and never passes a flip-flop.
    assign raw_cmp_out     = cmp_raw_in & on_ff;

endmodule

`default_nettype wire

// file: testbench/cmp_analog_model.sv
// Behavioural analog core that turns input voltage relations into raw comparator results.
`timescale 1ns/10ps
`default_nettype none

module cmp_analog_model
#(
    parameter int RESP_NS = 590
)
(
    input  wire logic [1:0] cmp_on,
    input  wire logic [1:0] plus_above,
    output var  logic [1:0] cmp_raw_in
);
    logic [1:0] settled = 2'h0;
    logic       junk    = 1'b0;

    // An unpowered core has no defined result, so it shows a level that keeps moving.
    always #7 junk = ~junk;

    always @(plus_above)
        settled <= #(RESP_NS) plus_above;

    always_comb
        cmp_raw_in = (cmp_on & settled) | (~cmp_on & {2{junk}});
endmodule

`default_nettype wire

// file: testbench/cmp_top_asserts.sv
// Concurrent checks on the ports of the comparator control block.
`timescale 1ns/10ps
`default_nettype none

module cmp_top_asserts
#(
    parameter int N_CMP = 2
)
(
    input  wire logic               clk_sys,
    input  wire logic               arst_n,
    input  wire logic [7:0]         sfr_addr,
    input  wire logic [7:0]         sfr_wdata,
    input  wire logic               sfr_wr,
    input  wire logic [N_CMP-1:0]   cmp_raw_in,
    input  wire logic               cmp0_reset_sel,
    input  wire logic [N_CMP-1:0]   cmp_on,
    input  wire cmp_pkg::cmp_hyst_t pos_hyst_sel [N_CMP],
    input  wire cmp_pkg::cmp_hyst_t neg_hyst_sel [N_CMP],
    input  wire cmp_pkg::cmp_sel2_t response_speed_sel [N_CMP],
    input  wire logic [N_CMP-1:0]   latched_cmp_out,
    input  wire logic [N_CMP-1:0]   raw_cmp_out,
    input  wire logic [N_CMP-1:0]   cmp_irq,
    input  wire logic               cmp0_reset_req
);
    import cmp_pkg::*;

    logic rise_en_ff;

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // Shadow of the channel 0 rising interrupt enable.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            rise_en_ff <= 1'b0;
        else if (sfr_wr && sfr_addr == 8'h9b)
            rise_en_ff <= sfr_wdata[5];
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_raw_gate;
        raw_cmp_out == (cmp_raw_in & cmp_on);
    endproperty
    a_raw_gate: assert property (p_raw_gate) else $error("raw output not gated");

    property p_write_on;
        sfr_wr && sfr_addr == 8'h9a |=> cmp_on[0] == $past(sfr_wdata[7]);
    endproperty
    a_write_on: assert property (p_write_on) else $error("enable not taken");

    property p_hyst;
        sfr_wr && sfr_addr == 8'h9a |=> pos_hyst_sel[0] == $past(sfr_wdata[3:2])
            && neg_hyst_sel[0] == $past(sfr_wdata[1:0]);
    endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis wrong");

    property p_speed;
        sfr_wr && sfr_addr == 8'h9e |=> response_speed_sel[1] == $past(sfr_wdata[1:0]);
    endproperty
    a_speed: assert property (p_speed) else $error("speed wrong");

    property p_latched_off;
        !cmp_on[0] [*2] |-> !latched_cmp_out[0];
    endproperty
    a_latched_off: assert property (p_latched_off) else $error("latched high off");

    property p_latched_follow;
        (cmp_on[0] && cmp_raw_in[0]) [*3] |=> latched_cmp_out[0];
    endproperty
    a_latched_follow: assert property (p_latched_follow) else $error("latched lags");

    property p_irq_rise;
        (rise_en_ff && cmp_on[0] && !cmp_raw_in[0]) ##1 (rise_en_ff && cmp_on[0] && cmp_raw_in[0]) [*3]
            |=> ##1 cmp_irq[0];
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("no rise irq");

    property p_reset_req;
        (cmp0_reset_sel && cmp_on[0] && !cmp_raw_in[0]) [*3] |=> cmp0_reset_req;
    endproperty
    a_reset_req: assert property (p_reset_req) else $error("no reset request");

    property p_reset_quiet;
        !cmp0_reset_sel |=> !cmp0_reset_req;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("stray reset request");
endmodule

bind cmp_top cmp_top_asserts #(.N_CMP(N_CMP)) i_cmp_top_asserts (.clk_sys(clk_sys), .arst_n(arst_n),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .cmp_raw_in(cmp_raw_in),
    .cmp0_reset_sel(cmp0_reset_sel), .cmp_on(cmp_on), .pos_hyst_sel(pos_hyst_sel),
    .neg_hyst_sel(neg_hyst_sel), .response_speed_sel(response_speed_sel),
    .latched_cmp_out(latched_cmp_out), .raw_cmp_out(raw_cmp_out), .cmp_irq(cmp_irq),
    .cmp0_reset_req(cmp0_reset_req));

`default_nettype wire

// file: testbench/testbench.sv
// Self-checking testbench for the comparator control block.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import cmp_pkg::*;

    logic       clk_sys;
    logic       arst_n;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_rdata;
    logic [1:0] cmp_raw_in;
    logic [1:0] plus_above;
    logic       cmp0_reset_sel;
    logic [1:0] cmp_on;
    cmp_hyst_t  pos_hyst_sel [2];
    cmp_hyst_t  neg_hyst_sel [2];
    cmp_sel2_t  response_speed_sel [2];
    cmp_sel2_t  plus_input_sel [2];
    cmp_sel2_t  minus_input_sel [2];
    logic [1:0] latched_cmp_out;
    logic [1:0] raw_cmp_out;
    logic [1:0] cmp_irq;
    logic       cmp0_reset_req;
    int         errors = 0;
    int         checks = 0;
    logic [7:0] ca [2] = '{8'h9a, 8'h9d};
    logic [7:0] ma [2] = '{8'h9b, 8'h9e};
    logic [7:0] ia [2] = '{8'h9f, 8'ha0};

    cmp_top i_cmp_top (.clk_sys(clk_sys), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .cmp_raw_in(cmp_raw_in),
        .cmp0_reset_sel(cmp0_reset_sel), .cmp_on(cmp_on), .pos_hyst_sel(pos_hyst_sel),
        .neg_hyst_sel(neg_hyst_sel), .response_speed_sel(response_speed_sel),
        .plus_input_sel(plus_input_sel), .minus_input_sel(minus_input_sel),
        .latched_cmp_out(latched_cmp_out), .raw_cmp_out(raw_cmp_out), .cmp_irq(cmp_irq),
        .cmp0_reset_req(cmp0_reset_req));

    cmp_analog_model i_cmp_analog_model (.cmp_on(cmp_on), .plus_above(plus_above), .cmp_raw_in(cmp_raw_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask

    // Each access ends with one idle cycle so that two calls in a row never pulse a strobe in one time step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
        tick(1);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        sfr_rd = 1'b1;
        tick(1);
        sfr_rd = 1'b0;
        chk(sfr_rdata, exp);
        tick(1);
    endtask

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals();
        chk(cmp_on, 8'h00);
        rchk(8'h9a, 8'h00);
        rchk(8'h9e, 8'h02);
        rchk(8'ha0, 8'h00);
        rchk(8'h9c, 8'h00);
    endtask

    task automatic t_regs();
        for (int c = 0; c < 2; c++)
        begin
            for (int i = 0; i < 4; i++)
            begin
                wr(ca[c], {4'h4, 2'(i), 2'(3 - i)});
                chk(pos_hyst_sel[c], 8'(i));
                chk(neg_hyst_sel[c], 8'(3 - i));
                rchk(ca[c], {4'h0, 2'(i), 2'(3 - i)});
                wr(ma[c], {6'h3f, 2'(i)});
                chk(response_speed_sel[c], 8'(i));
                rchk(ma[c], {4'h3, 2'h0, 2'(i)});
                wr(ia[c], {2'h3, 2'(i), 2'h3, 2'(3 - i)});
                chk(plus_input_sel[c], 8'(i));
                chk(minus_input_sel[c], 8'(3 - i));
                rchk(ia[c], {2'h0, 2'(i), 2'h0, 2'(3 - i)});
            end
        end
    endtask

    task automatic t_edges(input int c);
        wr(ma[c], 8'h20);
        wr(ca[c], 8'h80);
        chk(cmp_on[c], 8'h01);
        tick(30);
        wr(ca[c], 8'h80);
        tick(3);
        chk(cmp_irq[c], 8'h00);
        plus_above[c] = 1'b1;
        tick(30);
        chk(latched_cmp_out[c], 8'h01);
        chk(raw_cmp_out[c], 8'h01);
        chk(cmp_irq[c], 8'h01);
        rchk(ca[c], 8'he0);
        plus_above[c] = 1'b0;
        tick(30);
        rchk(ca[c], 8'hb0);
        wr(ma[c], 8'h10);
        wr(ca[c], 8'h90);
        tick(3);
        chk(cmp_irq[c], 8'h01);
        wr(ma[c], 8'h20);
        tick(3);
        chk(cmp_irq[c], 8'h00);
        wr(ca[c], 8'h80);
        rchk(ca[c], 8'h80);
    endtask

    task automatic t_off(input int c);
        plus_above[c] = 1'b1;
        tick(30);
        wr(ca[c], 8'h00);
        tick(10);
        chk(latched_cmp_out[c], 8'h00);
        chk(raw_cmp_out[c], 8'h00);
        chk(cmp_on[c], 8'h00);
        rchk(ca[c], 8'h00);
        plus_above[c] = 1'b0;
    endtask

    task automatic t_reset_req();
        wr(8'h9a, 8'h80);
        tick(30);
        cmp0_reset_sel = 1'b1;
        tick(3);
        chk(cmp0_reset_req, 8'h01);
        plus_above[0] = 1'b1;
        tick(30);
        chk(cmp0_reset_req, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        end_of_test();
    end

    initial
    begin
        arst_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        plus_above = 2'h0;
        cmp0_reset_sel = 1'b0;
        tick(8);
        arst_n = 1'b1;
        t_reset_vals();
        t_regs();
        t_edges(0);
        t_edges(1);
        t_off(0);
        t_off(1);
        t_reset_req();
        end_of_test();
    end
endmodule

`default_nettype wire
